// *** enhanced_spi_phase_sequencer_tb.sv ***
// self-checking bench for esps_top
// assumes the flash model on the lanes and apb on core_clk_i
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", n, e, s); end end
module enhanced_spi_phase_sequencer_tb;
  import esps_pkg::*;
  logic clk = 0, lclk = 0, rst = 1, psel = 0, pen = 0, pw = 0;
  logic [11:0] pa = 12'h0;
  logic [31:0] pwd = 32'h0, prd;
  logic prdy, perr, sclk, cs_n;
  logic [3:0] lo, loe, li;
  logic [63:0] cap;
  int nst, error_cnt = 0, n_checks = 0;
  logic [31:0] wd [4] = '{32'h9C, 32'h123456, 32'hDEADBEEF, 32'h0F0F0F0F};
  always #5 clk = ~clk;
  always #24 lclk = ~lclk;
  esps_top #(.HALF_CYC(4)) u_esps_top (.core_clk_i(clk), .rst_i(rst), .link_clk_i(lclk),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .sclk_o(sclk), .cs_n_o(cs_n),
    .lane_out_o(lo), .lane_oe_o(loe), .lane_in_i(li));
  esps_flash_model u_esps_flash_model (.sclk_i(sclk), .cs_n_i(cs_n), .out_i(lo),
    .oe_i(loe), .in_o(li), .nst_o(nst), .cap_o(cap));
  // ************
  // tasks
  // ************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pw <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // one transfer, then wait for idle and judge the wire
  task automatic go(input logic [31:0] c0, enh, input int nw, steps, input logic [63:0] ce);
    logic [31:0] r;
    logic e;
    int k;
    apb(1'b1, 12'h000, c0, r, e);
    apb(1'b1, 12'h004, enh, r, e);
    apb(1'b1, 12'h008, 32'h0, r, e);
    for (k = 0; k < nw; k++) apb(1'b1, 12'h00C, wd[k], r, e);
    r = 32'h4;
    // wait until the last word is taken, then until the engine is idle
    for (k = 0; k < 2000 && (r[2] !== 1'b0 || r[0] !== 1'b1); k++)
      apb(1'b0, 12'h010, 32'h0, r, e);
    `CHK("idle", 1'b0, r[2])
    `CHK("steps", steps, nst)
    `CHK("bits", ce, cap)
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h000, 32'h0, r, e);
    `CHK("ctrl0 rst", CTRL0_RST, r)
    apb(1'b1, 12'h000, 32'hFFFFFFFF, r, e);
    apb(1'b0, 12'h000, 32'h0, r, e);
    `CHK("ctrl0 mask", CTRL0_MASK, r)
    apb(1'b0, 12'h020, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
  endtask
  task automatic t_phases;
    go(32'h08, 32'h68, 3, 40, 64'h9C123456DEADBEEF);
    go(32'h08, 32'h69, 3, 22, 64'h9C123456DEADBEEF);
    go(32'h08, 32'h6A, 3, 16, 64'h9C123456DEADBEEF);
    go(32'h04, 32'h6A, 3, 32, 64'h9C123456DEADBEEF);
  endtask
  task automatic t_fallback;
    go(32'h00, 32'h6A, 3, 64, 64'h9C123456DEADBEEF);
    go(32'h09, 32'h6A, 3, 64, 64'h9C123456DEADBEEF);
    go(32'h0C, 32'h6A, 3, 64, 64'h9C123456DEADBEEF);
  endtask
  task automatic t_stream;
    go(32'h08, 32'h6A, 4, 24, 64'hDEADBEEF0F0F0F0F);
    go(32'h08, 32'h0A, 1, 2, 64'h9C);
    // 16-bit instruction, 36-bit address split over two entries
    go(32'h08, 32'h9E, 4, 21, 64'h0123456F0F0F0F0F);
  endtask
  task automatic t_read;
    logic [31:0] r;
    logic e;
    // target nibble counts falling sclk edges: 35 steps before data, then 8
    go(32'h18, 32'h368, 2, 43, 64'h9C123456);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    `CHK("rx word", 32'h3456789A, r)
    go(32'h18, 32'h068, 2, 40, 64'h9C123456);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    `CHK("rx word", 32'h01234567, r)
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ************
  // sequence
  // ************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // let the link side leave reset before the first request
    repeat (30) @(posedge clk);
    t_regs();
    t_phases();
    t_fallback();
    t_stream();
    t_read();
    finish_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
endmodule

// *** esps_flash_model.sv ***
// behavioural quad spi target for the sequencer bench
// assumes mode 0: lanes sampled on sclk rising edge
`timescale 1ns/1ps
module esps_flash_model (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  output logic [3:0] in_o,
  output int nst_o,
  output logic [63:0] cap_o
);
  // ************
  // capture
  // ************
  logic [3:0] nib;
  initial begin
    nst_o = 0;
    cap_o = 64'h0;
  end
  always @(negedge cs_n_i) begin
    nst_o = 0;
    cap_o = 64'h0;
    nib = 4'h0;
  end
  // new nibble after each falling sclk: a counting pattern exposes missed or extra shifts
  always @(negedge sclk_i) begin
    if (!cs_n_i) nib = nib + 4'h1;
  end
  always @(posedge sclk_i) begin
    if (!cs_n_i) begin
      nst_o++;
      case (oe_i)
        4'hF: cap_o = {cap_o[59:0], out_i};
        4'h3: cap_o = {cap_o[61:0], out_i[1:0]};
        4'h1: cap_o = {cap_o[62:0], out_i[0]};
        default: ;
      endcase
    end
  end
  // drive only once the lanes are released, else the inverse pattern
  assign in_o = (!cs_n_i && oe_i == 4'h0) ? nib : ~nib;
endmodule

// *** esps_pkg.sv ***
// shared constants, carriers and helpers for the enhanced spi phase sequencer
// assumes an apb master on the core clock and a dual or quad spi target on the lanes
package esps_pkg;

  // ************
  // register map
  // ************
  localparam logic [7:0] ESPS_CTRL0_OFS = 8'h00;
  localparam logic [7:0] ESPS_ENH_OFS = 8'h04;
  localparam logic [7:0] ESPS_CTRL1_OFS = 8'h08;
  localparam logic [7:0] ESPS_DATA_OFS = 8'h0C;
  localparam logic [7:0] ESPS_STAT_OFS = 8'h10;

  localparam int CTRL0_PROTO_LSB = 0;
  localparam int CTRL0_LANE_LSB = 2;
  localparam int CTRL0_READ_BIT = 4;
  localparam int ENH_PFS_LSB = 0;
  localparam int ENH_ILEN_LSB = 2;
  localparam int ENH_ALEN_LSB = 4;
  localparam int ENH_WAIT_LSB = 8;
  localparam int CTRL1_FRAMES_LSB = 0;

  localparam logic [31:0] CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] ENH_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL0_MASK = 32'h0000_001F;
  localparam logic [31:0] ENH_MASK = 32'h0000_1FFF;
  localparam logic [31:0] CTRL1_MASK = 32'h0000_FFFF;

  // ************
  // encodings and timing
  // ************
  localparam logic [1:0] PROTO_SPI = 2'h0;
  localparam logic [1:0] LANE_STD = 2'h0;
  localparam logic [1:0] LANE_DUAL = 2'h1;
  localparam logic [1:0] LANE_QUAD = 2'h2;
  localparam logic [1:0] PFS_STD = 2'h0;
  localparam logic [1:0] PFS_ADDR = 2'h1;
  localparam logic [1:0] PFS_ALL = 2'h2;
  localparam int SCLK_HALF_CYC = 4;
  localparam logic [6:0] FRAME_BITS = 7'h20;

  typedef struct packed {
    logic read;
    logic [1:0] proto;
    logic [1:0] lane;
    logic [1:0] pfs;
    logic [1:0] ilen;
    logic [3:0] alen;
    logic [4:0] wait_cyc;
    logic [15:0] frame_cnt;
  } esps_cfg_t;

  typedef struct packed {
    esps_cfg_t cfg;
    logic [31:0] word;
  } esps_item_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LEAD = 3'h1,
    ST_INST = 3'h3,
    ST_ADDR = 3'h2,
    ST_WAIT = 3'h6,
    ST_DATA = 3'h7,
    ST_DONE = 3'h5
  } esps_state_t;

  // ************
  // helpers
  // ************
  // the eight-lane code is unavailable and falls back to one lane
  function automatic logic esps_std(esps_cfg_t c);
    return (c.proto != PROTO_SPI) || (c.lane == LANE_STD) || (c.lane == 2'h3);
  endfunction

  function automatic logic [2:0] esps_width(esps_cfg_t c, esps_state_t s);
    logic [2:0] w;
    w = (c.lane == LANE_DUAL) ? 3'h2 : 3'h4;
    if (esps_std(c)) begin
      return 3'h1;
    end
    case (s)
      ST_INST: return (c.pfs == PFS_ALL) ? w : 3'h1;
      ST_ADDR: return (c.pfs == PFS_ADDR || c.pfs == PFS_ALL) ? w : 3'h1;
      default: return w;
    endcase
  endfunction

  function automatic logic [6:0] esps_ibits(esps_cfg_t c);
    case (c.ilen)
      2'h1: return 7'h04;
      2'h2: return 7'h08;
      2'h3: return 7'h10;
      default: return 7'h00;
    endcase
  endfunction

  function automatic logic [6:0] esps_abits(esps_cfg_t c);
    return {1'b0, c.alen, 2'b00};
  endfunction

  function automatic logic [1:0] esps_hdr(esps_cfg_t c);
    logic [1:0] a;
    a = (c.alen == 4'h0) ? 2'h0 : ((esps_abits(c) > 7'h20) ? 2'h2 : 2'h1);
    return a + {1'b0, c.ilen != 2'h0};
  endfunction

  function automatic logic [3:0] esps_mask(logic [2:0] w);
    return (w == 3'h4) ? 4'hF : ((w == 3'h2) ? 4'h3 : 4'h1);
  endfunction

endpackage

// *** esps_top.sv ***
// enhanced spi phase sequencer: apb registers, tx queue and serial engine
// assumes an apb master on core_clk_i and a dual or quad target on the lanes;
// link_clk_i is the serial engine clock, free running, sclk is derived from it
//
// Behaviour
// - standard lane format sends every phase on one lane, phase format ignored
// - lane format only acts when frame protocol is 00b
// - enhanced write sends header once, then data until queue empties
// - lane format 01 uses lanes 1:0, 10 uses lanes 3:0
// - phase format 00: instruction and address on one lane, data enhanced
// - phase format 01: instruction on one lane, address and data enhanced
// - phase format 10: instruction, address and data all enhanced
// - instruction-only writes are supported, enhanced under phase format 10
// - read order is instruction, address, turnaround, data
// - turnaround follows address directly, before any data sampling
// - turnaround count equals whole sclk periods, zero means none
// - read receives programmed frame count plus one, then releases target select
// - only dual and quad exist; lane buses are four bits
// - write waits until instruction and address entries are queued
// - instruction is one queue entry; address may span up to two
// - instruction length is 0, 4, 8 or 16 bits
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps

module esps_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_next;

  // a bit changes only once the second and third stage agree
  always_comb begin
    q_next = (s2_reg & ~(s2_reg ^ s3_reg)) | (q_o & (s2_reg ^ s3_reg));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_o <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_o <= q_next;
    end
  end
endmodule

module esps_top import esps_pkg::*; #(
  parameter int QDEPTH = 8,
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] lane_out_o,
  output logic [3:0] lane_oe_o,
  input wire logic [3:0] lane_in_i
);
  localparam int QAW = $clog2(QDEPTH);
  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);

  // ************
  // core domain: apb slave and handshakes
  // ************
  logic [31:0] ctrl0_reg, ctrl0_next, enh_reg, enh_next, ctrl1_reg, ctrl1_next;
  esps_item_t pend_reg, pend_next;
  logic pend_tog_reg, pend_tog_next;
  logic [31:0] rx_word_reg, rx_word_next, prdata_next;
  logic rx_valid_reg, rx_valid_next, rx_seen_reg, rx_seen_next;
  logic pready_next, pslverr_next;
  logic ack_q, rxt_q, busy_q, req_seen_reg, rxt_reg, busy_l_reg;
  logic [31:0] rxh_reg;
  esps_cfg_t cfg_sw;
  logic acc, done, tx_free, hi_zero;

  esps_sync3 #(.W(3)) u_core_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i({req_seen_reg, rxt_reg, busy_l_reg}),
    .q_o({ack_q, rxt_q, busy_q})
  );

  always_comb begin
    cfg_sw.read = ctrl0_reg[CTRL0_READ_BIT];
    cfg_sw.proto = ctrl0_reg[CTRL0_PROTO_LSB +: 2];
    cfg_sw.lane = ctrl0_reg[CTRL0_LANE_LSB +: 2];
    cfg_sw.pfs = enh_reg[ENH_PFS_LSB +: 2];
    cfg_sw.ilen = enh_reg[ENH_ILEN_LSB +: 2];
    cfg_sw.alen = enh_reg[ENH_ALEN_LSB +: 4];
    cfg_sw.wait_cyc = enh_reg[ENH_WAIT_LSB +: 5];
    cfg_sw.frame_cnt = ctrl1_reg[CTRL1_FRAMES_LSB +: 16];
  end

  assign acc = psel_i && penable_i && !pready_o;
  assign done = psel_i && penable_i && pready_o;
  assign tx_free = (ack_q == pend_tog_reg);
  assign hi_zero = (paddr_i[11:8] == 4'h0);

  always_comb begin
    ctrl0_next = ctrl0_reg;
    enh_next = enh_reg;
    ctrl1_next = ctrl1_reg;
    pend_next = pend_reg;
    pend_tog_next = pend_tog_reg;
    rx_word_next = rx_word_reg;
    rx_valid_next = rx_valid_reg;
    rx_seen_next = rx_seen_reg;
    prdata_next = prdata_o;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    // rx word is stable while its toggle is unanswered
    if (rxt_q != rx_seen_reg && !rx_valid_reg) begin
      rx_word_next = rxh_reg;
      rx_valid_next = 1'b1;
      rx_seen_next = rxt_q;
    end
    if (acc) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      if (!hi_zero) begin
        pslverr_next = 1'b1;
      end else begin
        case (paddr_i[7:0])
          ESPS_CTRL0_OFS: prdata_next = ctrl0_reg;
          ESPS_ENH_OFS: prdata_next = enh_reg;
          ESPS_CTRL1_OFS: prdata_next = ctrl1_reg;
          ESPS_STAT_OFS: prdata_next = {29'h0, busy_q, rx_valid_reg, tx_free};
          ESPS_DATA_OFS: begin
            prdata_next = rx_word_reg;
            pready_next = !pwrite_i || tx_free;
          end
          default: pslverr_next = 1'b1;
        endcase
      end
    end
    // writes and pops take effect only at the completing edge
    if (done && hi_zero && !pslverr_o) begin
      case (paddr_i[7:0])
        ESPS_CTRL0_OFS: if (pwrite_i) ctrl0_next = pwdata_i & CTRL0_MASK;
        ESPS_ENH_OFS: if (pwrite_i) enh_next = pwdata_i & ENH_MASK;
        ESPS_CTRL1_OFS: if (pwrite_i) ctrl1_next = pwdata_i & CTRL1_MASK;
        ESPS_DATA_OFS: begin
          if (pwrite_i) begin
            pend_next = '{cfg: cfg_sw, word: pwdata_i};
            pend_tog_next = !pend_tog_reg;
          end else begin
            rx_valid_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl0_reg <= CTRL0_RST;
      enh_reg <= ENH_RST;
      ctrl1_reg <= CTRL1_RST;
      pend_reg <= '0;
      pend_tog_reg <= 1'b0;
      rx_word_reg <= 32'h0000_0000;
      rx_valid_reg <= 1'b0;
      rx_seen_reg <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      ctrl0_reg <= ctrl0_next;
      enh_reg <= enh_next;
      ctrl1_reg <= ctrl1_next;
      pend_reg <= pend_next;
      pend_tog_reg <= pend_tog_next;
      rx_word_reg <= rx_word_next;
      rx_valid_reg <= rx_valid_next;
      rx_seen_reg <= rx_seen_next;
      prdata_o <= prdata_next;
      pready_o <= pready_next;
      pslverr_o <= pslverr_next;
    end
  end

  // ************
  // link domain: reset, crossings and queue
  // ************
  logic lrst_s1, lrst;
  logic req_q, rxa_q;
  logic [3:0] lin_q;
  esps_item_t q_mem [QDEPTH];
  logic [QAW-1:0] q_wr_reg, q_wr_next, q_rd_reg, q_rd_next;
  logic [QAW:0] q_cnt_reg, q_cnt_next;
  logic push, pop, req_seen_next, busy_l_next;
  esps_item_t q_head;

  always_ff @(posedge link_clk_i) begin
    lrst_s1 <= rst_i;
    lrst <= lrst_s1;
  end

  esps_sync3 #(.W(6)) u_link_sync (
    .clk_i(link_clk_i),
    .rst_i(lrst),
    .d_i({pend_tog_reg, rx_seen_reg, lane_in_i}),
    .q_o({req_q, rxa_q, lin_q})
  );

  assign q_head = q_mem[q_rd_reg];

  always_comb begin
    push = (req_q != req_seen_reg) && (q_cnt_reg != (QAW+1)'(QDEPTH));
    req_seen_next = push ? req_q : req_seen_reg;
    q_wr_next = push ? q_wr_reg + 1'b1 : q_wr_reg;
    q_rd_next = pop ? q_rd_reg + 1'b1 : q_rd_reg;
    q_cnt_next = q_cnt_reg + (QAW+1)'(push) - (QAW+1)'(pop);
  end

  always_ff @(posedge link_clk_i) begin
    if (push) begin
      q_mem[q_wr_reg] <= pend_reg;
    end
  end

  // ************
  // link domain: serial engine
  // ************
  esps_state_t st_reg, st_next, tgt;
  esps_cfg_t cfg_reg, cfg_next;
  logic [31:0] sh_reg, sh_next, rsh_reg, rsh_next, rxh_next, rs;
  logic [6:0] bits_reg, bits_next, n;
  logic [6:0] wl_reg, wl_next;
  logic [16:0] frames_reg, frames_next;
  logic [4:0] wait_reg, wait_next;
  logic [7:0] cnt_reg, cnt_next;
  logic half_reg, half_next, sclk_next, csn_next, rxt_next, enter, drive, tick, rx_free;
  logic [3:0] lout_next, loe_next;
  logic [2:0] w_cur, wn;

  assign w_cur = esps_width(cfg_reg, st_reg);
  assign tick = (cnt_reg == 8'h00);
  assign rx_free = (rxt_reg == rxa_q);

  always_comb begin
    tgt = st_reg;
    enter = 1'b0;
    pop = 1'b0;
    n = 7'h00;
    rs = rsh_reg;
    st_next = st_reg;
    cfg_next = cfg_reg;
    sh_next = sh_reg;
    rsh_next = rsh_reg;
    bits_next = bits_reg;
    wl_next = wl_reg;
    frames_next = frames_reg;
    wait_next = wait_reg;
    half_next = half_reg;
    cnt_next = tick ? HALF_M1 : cnt_reg - 8'h01;
    sclk_next = sclk_o;
    rxh_next = rxh_reg;
    rxt_next = rxt_reg;
    if (st_reg == ST_IDLE) begin
      half_next = 1'b0;
      cnt_next = HALF_M1;
      sclk_next = 1'b0;
      if (q_cnt_reg != '0 && q_cnt_reg >= (QAW+1)'(esps_hdr(q_head.cfg))) begin
        st_next = ST_LEAD;
        cfg_next = q_head.cfg;
      end
    end else if (tick && half_reg && st_reg == ST_DATA && cfg_reg.read &&
                 bits_reg == 7'(w_cur) && !rx_free) begin
      // previous frame not yet taken by the core side: hold sclk high
      cnt_next = 8'h00;
    end else if (tick && !half_reg) begin
      half_next = 1'b1;
      sclk_next = (st_reg != ST_LEAD) && (st_reg != ST_DONE);
    end else if (tick) begin
      half_next = 1'b0;
      sclk_next = 1'b0;
      sh_next = sh_reg << w_cur;
      bits_next = bits_reg - 7'(w_cur);
      wl_next = wl_reg - 7'(w_cur);
      case (st_reg)
        ST_LEAD: begin
          tgt = ST_INST;
          enter = 1'b1;
        end
        ST_INST: if (bits_reg == 7'(w_cur)) begin
          tgt = ST_ADDR;
          enter = 1'b1;
        end
        ST_ADDR: begin
          if (bits_reg == 7'(w_cur)) begin
            tgt = cfg_reg.read ? ST_WAIT : ST_DATA;
            enter = 1'b1;
          end else if (wl_reg == 7'(w_cur)) begin
            // address continues in the next queue entry
            pop = 1'b1;
            n = (bits_next > 7'h20) ? 7'h20 : bits_next;
          end
        end
        ST_WAIT: begin
          wait_next = wait_reg - 5'h01;
          if (wait_reg == 5'h01) begin
            tgt = ST_DATA;
            enter = 1'b1;
          end
        end
        ST_DATA: begin
          if (cfg_reg.read) begin
            case (w_cur)
              3'h4: rs = {rsh_reg[27:0], lin_q};
              3'h2: rs = {rsh_reg[29:0], lin_q[1:0]};
              default: rs = {rsh_reg[30:0], lin_q[1]};
            endcase
            rsh_next = rs;
            if (bits_reg == 7'(w_cur)) begin
              rxh_next = rs;
              rxt_next = !rxt_reg;
              if (frames_reg == 17'h0_0001) begin
                tgt = ST_DONE;
                enter = 1'b1;
              end else begin
                bits_next = FRAME_BITS;
                frames_next = frames_reg - 17'h0_0001;
              end
            end
          end else if (bits_reg == 7'(w_cur)) begin
            tgt = ST_DATA;
            enter = 1'b1;
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
    if (enter) begin
      if (tgt == ST_INST && cfg_reg.ilen == 2'h0) tgt = ST_ADDR;
      if (tgt == ST_ADDR && cfg_reg.alen == 4'h0) tgt = cfg_reg.read ? ST_WAIT : ST_DATA;
      if (tgt == ST_WAIT && cfg_reg.wait_cyc == 5'h00) tgt = ST_DATA;
      if (tgt == ST_DATA && !cfg_reg.read && q_cnt_reg == '0) tgt = ST_DONE;
      st_next = tgt;
      case (tgt)
        ST_INST: begin
          pop = 1'b1;
          n = esps_ibits(cfg_reg);
          bits_next = n;
        end
        ST_ADDR: begin
          pop = 1'b1;
          bits_next = esps_abits(cfg_reg);
          n = (bits_next > 7'h20) ? 7'h20 : bits_next;
        end
        ST_WAIT: wait_next = cfg_reg.wait_cyc;
        ST_DATA: begin
          bits_next = FRAME_BITS;
          if (cfg_reg.read) begin
            frames_next = {1'b0, cfg_reg.frame_cnt} + 17'h0_0001;
          end else begin
            pop = 1'b1;
            n = FRAME_BITS;
          end
        end
        default: ;
      endcase
    end
    if (pop) begin
      sh_next = q_head.word << (7'h20 - n);
      // a full 32-bit entry needs the sixth bit of the word-left count
      wl_next = n;
    end
    // lanes and enables follow the phase width; read turnaround and data leave the lanes to the target
    wn = esps_width(cfg_next, st_next);
    drive = (st_next == ST_INST) || (st_next == ST_ADDR) ||
            (st_next == ST_DATA && !cfg_next.read);
    loe_next = drive ? esps_mask(wn) : 4'h0;
    case (wn)
      3'h4: lout_next = sh_next[31:28];
      3'h2: lout_next = {2'b00, sh_next[31:30]};
      default: lout_next = {3'b000, sh_next[31]};
    endcase
    if (!drive) lout_next = 4'h0;
    csn_next = (st_next == ST_IDLE) || (st_next == ST_DONE);
    busy_l_next = (st_next != ST_IDLE) || (q_cnt_next != '0);
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      st_reg <= ST_IDLE;
      cfg_reg <= '0;
      sh_reg <= 32'h0000_0000;
      rsh_reg <= 32'h0000_0000;
      bits_reg <= 7'h00;
      wl_reg <= 7'h00;
      frames_reg <= 17'h0_0000;
      wait_reg <= 5'h00;
      cnt_reg <= HALF_M1;
      half_reg <= 1'b0;
      sclk_o <= 1'b0;
      cs_n_o <= 1'b1;
      lane_out_o <= 4'h0;
      lane_oe_o <= 4'h0;
      rxh_reg <= 32'h0000_0000;
      rxt_reg <= 1'b0;
      req_seen_reg <= 1'b0;
      busy_l_reg <= 1'b0;
      q_wr_reg <= '0;
      q_rd_reg <= '0;
      q_cnt_reg <= '0;
    end else begin
      st_reg <= st_next;
      cfg_reg <= cfg_next;
      sh_reg <= sh_next;
      rsh_reg <= rsh_next;
      bits_reg <= bits_next;
      wl_reg <= wl_next;
      frames_reg <= frames_next;
      wait_reg <= wait_next;
      cnt_reg <= cnt_next;
      half_reg <= half_next;
      sclk_o <= sclk_next;
      cs_n_o <= csn_next;
      lane_out_o <= lout_next;
      lane_oe_o <= loe_next;
      rxh_reg <= rxh_next;
      rxt_reg <= rxt_next;
      req_seen_reg <= req_seen_next;
      busy_l_reg <= busy_l_next;
      q_wr_reg <= q_wr_next;
      q_rd_reg <= q_rd_next;
      q_cnt_reg <= q_cnt_next;
    end
  end

  // ************
  // checks on the serial engine
  // ************
  logic [15:0] wait_cyc_reg;
  logic [3:0] dmask;
  logic enh;
  assign dmask = (cfg_reg.lane == LANE_DUAL) ? 4'h3 : 4'hF;
  assign enh = !esps_std(cfg_reg);

  always_ff @(posedge link_clk_i) begin
    if (lrst || st_reg == ST_LEAD) wait_cyc_reg <= 16'h0000;
    else if (st_reg == ST_WAIT) wait_cyc_reg <= wait_cyc_reg + 16'h0001;
  end

  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (lrst);

  sequence s_addr_out_rd;
    cfg_reg.read && st_reg == ST_ADDR ##1 st_reg != ST_ADDR;
  endsequence
  sequence s_start;
    st_reg == ST_IDLE ##1 st_reg == ST_LEAD;
  endsequence

  property p_std_one_lane;
    (st_reg != ST_IDLE && !enh) |-> lane_oe_o[3:1] == 3'h0;
  endproperty
  a_std_one_lane: assert property (p_std_one_lane) else $error("extra lane driven");
  property p_proto;
    (st_reg != ST_IDLE && cfg_reg.proto != PROTO_SPI) |-> lane_out_o[3:1] == 3'h0;
  endproperty
  a_proto: assert property (p_proto) else $error("lanes used outside spi");
  property p_write_drains;
    (st_reg == ST_DATA && !cfg_reg.read && tick && half_reg && bits_reg == 7'(w_cur)
     && q_cnt_reg != '0) |=> st_reg == ST_DATA && !cs_n_o;
  endproperty
  a_write_drains: assert property (p_write_drains) else $error("write stopped early");
  property p_lanes;
    (st_reg == ST_DATA && !cfg_reg.read && enh) |-> lane_oe_o == dmask;
  endproperty
  a_lanes: assert property (p_lanes) else $error("wrong data lanes");
  property p_pfs_std;
    (enh && cfg_reg.pfs == PFS_STD && (st_reg == ST_INST || st_reg == ST_ADDR))
      |-> lane_oe_o == 4'h1;
  endproperty
  a_pfs_std: assert property (p_pfs_std) else $error("header not single lane");
  property p_pfs_addr;
    (enh && cfg_reg.pfs == PFS_ADDR) |->
      (st_reg != ST_INST || lane_oe_o == 4'h1) && (st_reg != ST_ADDR || lane_oe_o == dmask);
  endproperty
  a_pfs_addr: assert property (p_pfs_addr) else $error("address format wrong");
  property p_pfs_all;
    (enh && cfg_reg.pfs == PFS_ALL && st_reg == ST_INST) |-> lane_oe_o == dmask;
  endproperty
  a_pfs_all: assert property (p_pfs_all) else $error("instruction not enhanced");
  property p_order;
    s_addr_out_rd |-> st_reg == ST_WAIT || st_reg == ST_DATA;
  endproperty
  a_order: assert property (p_order) else $error("read phase order broken");
  property p_wait_len;
    $fell(st_reg == ST_WAIT) |->
      wait_cyc_reg == 16'(cfg_reg.wait_cyc) * 16'(2 * HALF_CYC);
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("turnaround length wrong");
  property p_wait_release;
    st_reg == ST_WAIT |-> lane_oe_o == 4'h0 && !cs_n_o;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("lanes driven in turnaround");
  property p_cs_hold;
    (st_reg == ST_INST || st_reg == ST_ADDR || st_reg == ST_WAIT || st_reg == ST_DATA)
      |-> !cs_n_o;
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("select gap in transfer");
  property p_rd_end;
    (st_reg == ST_DATA && cfg_reg.read && tick && half_reg && bits_reg == 7'(w_cur)
     && frames_reg == 17'h0_0001 && rx_free) |=> cs_n_o && st_reg == ST_DONE;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("select not released");
  property p_start;
    s_start |-> $past(q_cnt_reg) >= (QAW+1)'(esps_hdr(cfg_reg));
  endproperty
  a_start: assert property (p_start) else $error("started without header");
  property p_inst_len;
    $rose(st_reg == ST_INST) |-> bits_reg == esps_ibits(cfg_reg);
  endproperty
  a_inst_len: assert property (p_inst_len) else $error("instruction length wrong");
endmodule
